// >>> phf_pkg.sv
// Purpose: Shared constants and types for the packet header capture block
// Assumes: One system clock; all DRAM bus pins are asynchronous to it
// Notes:   Control pin bit order inside the sampled vector is fixed below
package phf_pkg;
  localparam int DATA_W      = 32;
  localparam int FIFO_DEPTH  = 1024;
  localparam int CTRL_W      = 5;
  localparam int PKT_CNT_W   = 16;
  localparam int WORD_CNT_W  = 3;
  // Bit positions in the sampled control vector
  localparam int SIG_CAS     = 0;
  localparam int SIG_RAS0    = 1;
  localparam int SIG_RAS1    = 2;
  localparam int SIG_HDR     = 3;
  localparam int SIG_EDO     = 4;
  // Idle pin levels: strobes high, timing select low
  localparam logic [CTRL_W-1:0]     CTRL_IDLE    = 5'h0f;
  localparam logic [WORD_CNT_W-1:0] HDR_WORDS    = 3'h4;
  localparam logic [WORD_CNT_W-1:0] WORD_CNT_RST = 3'h0;
  localparam logic [WORD_CNT_W-1:0] WORD_INC     = 3'h1;
  localparam logic [PKT_CNT_W-1:0]  PKT_CNT_RST  = 16'h0000;
  localparam logic [PKT_CNT_W-1:0]  PKT_INC      = 16'h0001;
  localparam logic [DATA_W-1:0]     DATA_RST     = 32'h00000000;
  typedef enum logic {HDR_IDLE, HDR_ACTIVE} phf_hdr_t;
endpackage

// >>> phf_fifo.sv
// Purpose: Synchronous FIFO holding captured header words
// Assumes: Writes and reads on the same clock
// Notes:   Output word is registered; full and valid come from flops
`timescale 1ns/1ns
module phf_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 1024,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Write side
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  // Read side
  input  wire logic         rd_ready,
  output logic              rd_valid,
  output logic [W-1:0]      rd_data,
  output logic [AW:0]       level
);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          full;
    logic          rd_valid;
    logic [W-1:0]  rd_data;
  } phf_fifo_st_t;

  localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0]   CNT_ONE  = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);

  phf_fifo_st_t st_r;
  phf_fifo_st_t st_nxt;
  logic [W-1:0] mem [DEPTH];
  logic         do_wr;
  logic         do_rd;

  // Word stored only when the source offers it and room remains
  assign do_wr    = wr_valid && !st_r.full;
  assign do_rd    = (st_r.count != '0) && (!st_r.rd_valid || rd_ready);
  assign wr_ready = !st_r.full;
  assign rd_valid = st_r.rd_valid;
  assign rd_data  = st_r.rd_data;
  assign level    = st_r.count;

  always_comb begin
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.wr_ptr = st_r.wr_ptr + PTR_ONE;
    end
    if (st_r.rd_valid && rd_ready) begin
      st_nxt.rd_valid = 1'b0;
    end
    if (do_rd) begin
      st_nxt.rd_data  = mem[st_r.rd_ptr];
      st_nxt.rd_valid = 1'b1;
      st_nxt.rd_ptr   = st_r.rd_ptr + PTR_ONE;
    end
    if (do_wr && !do_rd) begin
      st_nxt.count = st_r.count + CNT_ONE;
    end else if (do_rd && !do_wr) begin
      st_nxt.count = st_r.count - CNT_ONE;
    end
    st_nxt.full = (st_nxt.count == CNT_FULL);
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[st_r.wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// >>> phf_capture.sv
// Purpose: Snoops the packet DRAM bus and loads header words into a FIFO
// Assumes: Controller runs fast page timing whenever capture is wanted
// Notes:   CAS rise acts as the FIFO write edge, seen through synchronisers
`timescale 1ns/1ns
module phf_capture #(
  parameter int DATA_W = phf_pkg::DATA_W,
  parameter int DEPTH  = phf_pkg::FIFO_DEPTH,
  parameter int AW     = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // DRAM bus pins
  input  wire logic              cas_n,
  input  wire logic              ras0_n,
  input  wire logic              ras1_n,
  input  wire logic              header_read_strobe_n,
  input  wire logic [DATA_W-1:0] dram_data,
  input  wire logic              extended_data_out_timing,
  // Gating status
  output logic                   gated_write_enable_n,
  output logic                   refresh_active,
  output logic                   edo_blocked,
  // Counters and flags
  input  wire logic              clear_flags,
  output logic [phf_pkg::WORD_CNT_W-1:0] header_word_count,
  output logic [phf_pkg::PKT_CNT_W-1:0]  packet_count,
  output logic                   fifo_overflow,
  output logic                   header_overrun,
  // FIFO read side
  input  wire logic              rd_ready,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output logic [AW:0]            fifo_level
);
  typedef struct packed {
    logic [phf_pkg::CTRL_W-1:0]     s1;
    logic [phf_pkg::CTRL_W-1:0]     s2;
    logic [phf_pkg::CTRL_W-1:0]     s3;
    logic [phf_pkg::CTRL_W-1:0]     ctrl_f;
    logic [DATA_W-1:0]              d1;
    logic [DATA_W-1:0]              d2;
    logic [DATA_W-1:0]              d3;
    logic [DATA_W-1:0]              hold;
    logic                           cas_prev;
    logic                           refresh;
    logic                           gated_n;
    logic                           push;
    logic [DATA_W-1:0]              push_data;
    phf_pkg::phf_hdr_t              hdr_state;
    logic [phf_pkg::WORD_CNT_W-1:0] word_cnt;
    logic [phf_pkg::PKT_CNT_W-1:0]  pkt_cnt;
    logic                           overflow;
    logic                           overrun;
  } phf_st_t;

  phf_st_t st_r;
  phf_st_t st_nxt;
  logic    wr_ready;
  logic    cas_low;
  logic    ras0_low;
  logic    ras1_low;
  logic    hdr_low;
  logic    cas_rise;
  logic    fire;

  phf_fifo #(
    .W     (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wr_valid (st_r.push),
    .wr_data  (st_r.push_data),
    .wr_ready (wr_ready),
    .rd_ready (rd_ready),
    .rd_valid (rd_valid),
    .rd_data  (rd_data),
    .level    (fifo_level)
  );

  assign cas_low  = !st_r.ctrl_f[phf_pkg::SIG_CAS];
  assign ras0_low = !st_r.ctrl_f[phf_pkg::SIG_RAS0];
  assign ras1_low = !st_r.ctrl_f[phf_pkg::SIG_RAS1];
  assign hdr_low  = !st_r.ctrl_f[phf_pkg::SIG_HDR];
  // Write edge is the CAS deassertion, as a rising write clock would see it
  assign cas_rise = !st_r.cas_prev && st_r.ctrl_f[phf_pkg::SIG_CAS];
  // Stored only on that edge with enable low and fast page timing selected
  assign fire     = cas_rise && !st_r.gated_n && !st_r.ctrl_f[phf_pkg::SIG_EDO];

  always_comb begin
    st_nxt    = st_r;
    // Three-stage pin capture; first stage feeds only the second
    st_nxt.s1 = {extended_data_out_timing, header_read_strobe_n, ras1_n, ras0_n, cas_n};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.d1 = dram_data;
    st_nxt.d2 = st_r.d1;
    st_nxt.d3 = st_r.d2;
    for (int i = 0; i < phf_pkg::CTRL_W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.ctrl_f[i] = st_r.s3[i];
      end
    end
    st_nxt.cas_prev = st_r.ctrl_f[phf_pkg::SIG_CAS];
    // Refresh latch
    if (cas_low && !ras0_low && !ras1_low) begin
      st_nxt.refresh = 1'b1;
    end else if (!cas_low && !ras0_low && !ras1_low) begin
      st_nxt.refresh = 1'b0;
    end
    // Gated enable follows the strobe while a RAS is low, unless refresh holds it high
    st_nxt.gated_n = !(!st_nxt.refresh && (ras0_low || ras1_low) && hdr_low);
    // Data held only while CAS is low; EXTENDED_DATA_OUT_TIMING data after CAS rise is never taken
    if (cas_low && !st_r.s3[phf_pkg::SIG_CAS]) begin
      st_nxt.hold = st_r.d3;
    end
    // Header phase and per-packet word count
    st_nxt.push = 1'b0;
    case (st_r.hdr_state)
      phf_pkg::HDR_IDLE: begin
        if (hdr_low) begin
          st_nxt.hdr_state = phf_pkg::HDR_ACTIVE;
          st_nxt.word_cnt  = phf_pkg::WORD_CNT_RST;
        end
      end
      phf_pkg::HDR_ACTIVE: begin
        if (!hdr_low && !fire) begin
          st_nxt.hdr_state = phf_pkg::HDR_IDLE;
          if (st_r.word_cnt != phf_pkg::WORD_CNT_RST) begin
            st_nxt.pkt_cnt = st_r.pkt_cnt + phf_pkg::PKT_INC;
          end
        end
      end
      default: begin
        st_nxt.hdr_state = phf_pkg::HDR_IDLE;
      end
    endcase
    if (fire) begin
      if (st_r.word_cnt == phf_pkg::HDR_WORDS) begin
        st_nxt.overrun = 1'b1;
      end else begin
        st_nxt.push      = 1'b1;
        st_nxt.push_data = st_r.hold;
        st_nxt.word_cnt  = st_r.word_cnt + phf_pkg::WORD_INC;
      end
    end
    // Sticky flags; a new event wins over a clear
    if (clear_flags) begin
      st_nxt.overflow = 1'b0;
      if (!(fire && st_r.word_cnt == phf_pkg::HDR_WORDS)) begin
        st_nxt.overrun = 1'b0;
      end
    end
    if (st_r.push && !wr_ready) begin
      st_nxt.overflow = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r           <= '0;
      st_r.s1        <= phf_pkg::CTRL_IDLE;
      st_r.s2        <= phf_pkg::CTRL_IDLE;
      st_r.s3        <= phf_pkg::CTRL_IDLE;
      st_r.ctrl_f    <= phf_pkg::CTRL_IDLE;
      st_r.cas_prev  <= 1'b1;
      st_r.gated_n   <= 1'b1;
      st_r.hdr_state <= phf_pkg::HDR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gated_write_enable_n = st_r.gated_n;
  assign refresh_active       = st_r.refresh;
  assign edo_blocked          = st_r.ctrl_f[phf_pkg::SIG_EDO];
  assign header_word_count    = st_r.word_cnt;
  assign packet_count         = st_r.pkt_cnt;
  assign fifo_overflow        = st_r.overflow;
  assign header_overrun       = st_r.overrun;

  AST_REFRESH_BLOCKS_WE: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.refresh |-> st_r.gated_n) else $error("write enable low during refresh");
  AST_WE_NEEDS_CAUSE: assert property (@(posedge clk) disable iff (sys_rst)
    !st_r.gated_n |-> $past(hdr_low) && ($past(ras0_low) || $past(ras1_low)))
    else $error("write enable low without strobe and RAS");
  AST_REFRESH_SET: assert property (@(posedge clk) disable iff (sys_rst)
    (cas_low && !ras0_low && !ras1_low) |=> st_r.refresh) else $error("refresh latch did not set");
  AST_REFRESH_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    (!cas_low && !ras0_low && !ras1_low) |=> !st_r.refresh) else $error("refresh latch did not clear");
  AST_PUSH_ON_CAS_RISE: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.push |-> $past(st_r.ctrl_f[phf_pkg::SIG_CAS]) && !$past(st_r.cas_prev))
    else $error("word stored without CAS rise");
  AST_PUSH_NEEDS_WE: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.push |-> !$past(st_r.gated_n)) else $error("word stored with enable high");
  AST_EDO_BLOCKS: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.ctrl_f[phf_pkg::SIG_EDO] |=> !st_r.push) else $error("word stored in EXTENDED_DATA_OUT_TIMING timing");
  AST_FOUR_WORDS: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.word_cnt <= phf_pkg::HDR_WORDS) else $error("more than four words in one header");
  AST_HOLD_CAS_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(st_r.hold) |-> $past(cas_low)) else $error("data sampled outside CAS low");
  AST_WE_PASS_THROUGH: assert property (@(posedge clk) disable iff (sys_rst)
    (hdr_low && (ras0_low || ras1_low) && !st_r.refresh) |=> !st_r.gated_n)
    else $error("write enable high although strobe passes");
  AST_OVERFLOW_SET: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.push && !wr_ready) |=> st_r.overflow) else $error("dropped word not flagged");
endmodule

// >>> phf_ctrl_model.sv
// Purpose: Switching controller model driving the packet DRAM bus
// Assumes: Fast page timing; tasks are entered just after a rising clk edge
// Notes:   Data bus shows inverted last word once CAS releases it
`timescale 1ns/1ns
module phf_ctrl_model (
  // Clock
  input  wire logic        clk,
  // DRAM bus pins
  output logic             cas_n,
  output logic             ras0_n,
  output logic             ras1_n,
  output logic             header_read_strobe_n,
  output logic [31:0]      dram_data,
  output logic             extended_data_out_timing
);
  initial begin
    cas_n = 1'b1;
    ras0_n = 1'b1;
    ras1_n = 1'b1;
    header_read_strobe_n = 1'b1;
    dram_data = 32'hffffffff;
    extended_data_out_timing = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic set_edo(input logic v);
    extended_data_out_timing <= v;
    step(6);
  endtask
  // One CAS pulse; word driven while CAS low, its inverse once CAS rises
  task automatic cas_pulse(input logic [31:0] w);
    cas_n <= 1'b0;
    dram_data <= w;
    step(6);
    cas_n <= 1'b1;
    dram_data <= ~w;
    step(6);
  endtask
  // Strobe low only around the header word reads
  task automatic header(input int n, input logic [31:0] base, input logic bank);
    header_read_strobe_n <= 1'b0;
    if (bank) ras1_n <= 1'b0;
    else ras0_n <= 1'b0;
    step(6);
    for (int i = 0; i < n; i++) cas_pulse(base + 32'(i));
    header_read_strobe_n <= 1'b1;
    ras0_n <= 1'b1;
    ras1_n <= 1'b1;
    step(10);
  endtask
  // CAS before RAS refresh with the strobe left asserted
  task automatic refresh;
    header_read_strobe_n <= 1'b0;
    cas_n <= 1'b0;
    step(6);
    ras0_n <= 1'b0;
    step(6);
    ras0_n <= 1'b1;
    cas_n <= 1'b1;
    step(4);
    header_read_strobe_n <= 1'b1;
    step(8);
  endtask
endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the header capture block
// Assumes: Small FIFO depth to reach overflow quickly
// Notes:   Reads happen only in the drain task
`timescale 1ns/1ns
module tb;
  localparam int DEPTH = 8;
  logic                     clk = 1'b0;
  logic                     sys_rst = 1'b1;
  logic                     clear_flags = 1'b0;
  logic                     rd_ready = 1'b0;
  logic                     cas_n, ras0_n, ras1_n, hdr_n, edo_sel;
  logic                     gated_write_enable_n, refresh_active, edo_blocked;
  logic [31:0]              dram_data, rd_data;
  logic [2:0]               header_word_count;
  logic [15:0]              packet_count;
  logic                     fifo_overflow, header_overrun, rd_valid;
  logic [$clog2(DEPTH):0]   fifo_level;
  int                       err_total = 0;
  int                       compares = 0;
  always #2 clk = ~clk;
  phf_ctrl_model ctl (.clk(clk), .cas_n(cas_n), .ras0_n(ras0_n), .ras1_n(ras1_n),
    .header_read_strobe_n(hdr_n), .dram_data(dram_data), .extended_data_out_timing(edo_sel));
  phf_capture #(.DEPTH(DEPTH)) DUT (.clk(clk), .sys_rst(sys_rst), .cas_n(cas_n), .ras0_n(ras0_n),
    .ras1_n(ras1_n), .header_read_strobe_n(hdr_n), .dram_data(dram_data),
    .extended_data_out_timing(edo_sel), .gated_write_enable_n(gated_write_enable_n),
    .refresh_active(refresh_active), .edo_blocked(edo_blocked), .clear_flags(clear_flags),
    .header_word_count(header_word_count), .packet_count(packet_count), .fifo_overflow(fifo_overflow),
    .header_overrun(header_overrun), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .fifo_level(fifo_level));
  task automatic final_report;
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads every word out and compares the first n against base+i
  task automatic drain(input logic [31:0] base, input int n, output int cnt);
    logic [31:0] q[$];
    rd_ready <= 1'b1;
    repeat (40) begin
      @(negedge clk);
      if (rd_valid === 1'b1) q.push_back(rd_data);
    end
    @(posedge clk);
    rd_ready <= 1'b0;
    cnt = q.size();
    for (int i = 0; i < n && i < cnt; i++) chk(q[i], base + 32'(i));
  endtask
  task automatic t_basic;
    int cnt;
    ctl.header(4, 32'ha5a50000, 1'b0);
    chk(packet_count, 32'h1);
    chk(header_word_count, 32'h4);
    chk(fifo_level, 32'h3);
    chk(rd_valid, 1'b1);
    drain(32'ha5a50000, 4, cnt);
    chk(cnt, 4);
    $display("basic header test done");
  endtask
  task automatic t_overrun;
    int cnt;
    ctl.header(5, 32'h5a5a0000, 1'b1);
    chk(header_overrun, 1'b1);
    chk(packet_count, 32'h2);
    drain(32'h5a5a0000, 4, cnt);
    chk(cnt, 4);
    clear_flags <= 1'b1;
    @(posedge clk);
    clear_flags <= 1'b0;
    repeat (3) @(posedge clk);
    chk(header_overrun, 1'b0);
    $display("overrun test done");
  endtask
  task automatic t_refresh;
    int low_seen;
    int ref_seen;
    low_seen = 0;
    ref_seen = 0;
    fork
      ctl.refresh();
      repeat (36) begin
        @(negedge clk);
        if (gated_write_enable_n !== 1'b1) low_seen++;
        if (refresh_active === 1'b1) ref_seen++;
      end
    join
    @(posedge clk);
    chk(low_seen, 0);
    chk(ref_seen > 0, 1'b1);
    chk(refresh_active, 1'b0);
    chk(rd_valid, 1'b0);
    $display("refresh test done");
  endtask
  task automatic t_edo;
    int cnt;
    ctl.set_edo(1'b1);
    ctl.header(4, 32'h0bad0000, 1'b0);
    chk(edo_blocked, 1'b1);
    drain(32'h0, 0, cnt);
    chk(cnt, 0);
    ctl.set_edo(1'b0);
    $display("timing select test done");
  endtask
  task automatic t_overflow;
    int cnt;
    for (int h = 0; h < 3; h++) ctl.header(4, 32'hc0de0000 + 32'(4 * h), h[0]);
    chk(fifo_overflow, 1'b1);
    chk(fifo_level, 32'(DEPTH));
    drain(32'hc0de0000, DEPTH, cnt);
    chk(cnt, 32'(DEPTH + 1));
    $display("overflow test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_basic();
    t_overrun();
    t_refresh();
    t_edo();
    t_overflow();
    final_report();
  end
  initial begin
    #40000;
    err_total++;
    final_report();
  end
endmodule
